//--- pkg/probe_pkg.sv
// constants for the touch probe position capture unit
package probe_pkg;
	// ====================================================
	// object addresses
	localparam logic [15:0] ADDR_CONTROL = 16'h60b8;
	localparam logic [15:0] ADDR_STATUS = 16'h60b9;
	// ====================================================
	// control fields
	localparam int CTL_ARM1 = 0;
	localparam int CTL_CONT1 = 1;
	localparam int CTL_SRC1 = 2;
	localparam int CTL_RISE1 = 4;
	localparam int CTL_FALL1 = 5;
	localparam int CTL_ARM2 = 8;
	localparam int CTL_CONT2 = 9;
	localparam int CTL_SRC2 = 10;
	localparam int CTL_RISE2 = 12;
	localparam int CTL_FALL2 = 13;
	localparam logic [15:0] CTL_WRITE_MASK = 16'h3737;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	// ====================================================
	// status fields
	localparam int STS_ACT1 = 0;
	localparam int STS_RISE1 = 1;
	localparam int STS_FALL1 = 2;
	localparam int STS_ACT2 = 8;
	localparam int STS_RISE2 = 9;
	localparam int STS_FALL2 = 10;
	localparam logic [15:0] STS_RESET = 16'h0000;
	localparam int POS_W = 32;
endpackage

//--- src/probe_channel.sv
// one probe channel: arm, mode, edge enables, capture
`timescale 1ns/1ps
module probe_channel #(
	parameter int POS_W = 32
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic arm_in,
	input wire logic cont_in,
	input wire logic rise_en_in,
	input wire logic fall_en_in,
	input wire logic rise_in,
	input wire logic fall_in,
	input wire logic [POS_W-1:0] pos_in,
	output logic active_out,
	output logic rise_done_out,
	output logic fall_done_out,
	output logic [POS_W-1:0] rise_pos_out,
	output logic [POS_W-1:0] fall_pos_out
);
	logic take_rise;
	logic take_fall;

	// single shot blocks further edges of the same kind
	assign take_rise = arm_in & rise_en_in & rise_in & (cont_in | ~rise_done_out);
	assign take_fall = arm_in & fall_en_in & fall_in & (cont_in | ~fall_done_out);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			active_out <= 1'b0;
		end else begin
			active_out <= arm_in;
		end
	end

	// disarm clears the flags, so a re-arm starts clean
	always_ff @(posedge clk_in) begin
		if (srst_in || !arm_in) begin
			rise_done_out <= 1'b0;
			fall_done_out <= 1'b0;
		end else begin
			if (take_rise) begin
				rise_done_out <= 1'b1;
			end
			if (take_fall) begin
				fall_done_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rise_pos_out <= '0;
			fall_pos_out <= '0;
		end else begin
			if (take_rise) begin
				rise_pos_out <= pos_in;
			end
			if (take_fall) begin
				fall_pos_out <= pos_in;
			end
		end
	end
endmodule

//--- src/probe_edge.sv
// edge detector for one trigger source
`timescale 1ns/1ps
module probe_edge (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic sig_in,
	output logic rise_out,
	output logic fall_out
);
	logic prev_q;
	logic valid_q;

	// first cycle after reset sees no edge, avoids a false capture
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prev_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			prev_q <= sig_in;
			valid_q <= 1'b1;
		end
	end

	assign rise_out = valid_q & sig_in & ~prev_q;
	assign fall_out = valid_q & ~sig_in & prev_q;
endmodule

//--- src/touch_probe_position_capture.sv
// touch probe position capture unit, top level
// ====================================================
// Operation
// - an armed channel stores the motor position on each enabled trigger edge in continuous mode, on the first of each kind only in single-shot.
// - control bit 0 arms channel one when set and disarms it when clear.
// - control bit 8 arms channel two when set and disarms it when clear.
// - control bits 1 and 9 pick single-shot when zero and continuous when one.
// - control bit 2 picks channel one's pin when zero, the zero pulse when one.
// - control bit 10 picks channel two's pin when zero, the zero pulse when one.
// - control bits 4 and 12 enable capture on a rising edge.
// - control bits 5 and 13 enable capture on a falling edge.
// - status bit 0 shows channel one armed.
// - status bit 8 shows channel two armed.
// - status bit 1 shows channel one captured on a rising edge.
// - status bit 2 shows channel one captured on a falling edge.
// - status bit 9 shows channel two captured on a rising edge.
// - status bit 10 shows channel two captured on a falling edge.
`timescale 1ns/1ps
module touch_probe_position_capture
	import probe_pkg::*;
#(
	parameter int POS_WIDTH = POS_W
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic probe1_in,
	input wire logic probe2_in,
	input wire logic zero_pulse_in,
	input wire logic [POS_WIDTH-1:0] position_in,
	input wire logic obj_wr_in,
	input wire logic obj_rd_in,
	input wire logic [15:0] obj_addr_in,
	input wire logic [15:0] obj_wdata_in,
	output logic [15:0] obj_rdata_out,
	output logic obj_rvalid_out,
	output logic obj_err_out,
	output logic [POS_WIDTH-1:0] pos1_rise_out,
	output logic [POS_WIDTH-1:0] pos1_fall_out,
	output logic [POS_WIDTH-1:0] pos2_rise_out,
	output logic [POS_WIDTH-1:0] pos2_fall_out
);
	// ====================================================
	// request decode
	logic hit_ctl;
	logic hit_sts;
	logic wr_ctl;
	logic wr_bad;
	logic rd_ctl;
	logic rd_sts;
	logic rd_bad;

	assign hit_ctl = (obj_addr_in == ADDR_CONTROL);
	assign hit_sts = (obj_addr_in == ADDR_STATUS);
	assign wr_ctl = obj_wr_in & hit_ctl;
	// status is read-only, so a write there is refused like an unknown index
	assign wr_bad = obj_wr_in & ~hit_ctl;
	assign rd_ctl = obj_rd_in & hit_ctl;
	assign rd_sts = obj_rd_in & hit_sts;
	assign rd_bad = obj_rd_in & ~hit_ctl & ~hit_sts;

	// ====================================================
	// control object
	logic [15:0] ctl_q;
	logic [15:0] wdata_masked;

	// reserved bits never reach the register
	assign wdata_masked = obj_wdata_in & CTL_WRITE_MASK;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctl_q <= CTL_RESET;
		end else if (wr_ctl) begin
			ctl_q <= wdata_masked;
		end
	end

	// ====================================================
	// control fields, channel one
	logic arm1;
	logic cont1;
	logic src1;
	logic rise_en1;
	logic fall_en1;

	assign arm1 = ctl_q[CTL_ARM1];
	assign cont1 = ctl_q[CTL_CONT1];
	assign src1 = ctl_q[CTL_SRC1];
	assign rise_en1 = ctl_q[CTL_RISE1];
	assign fall_en1 = ctl_q[CTL_FALL1];

	// ====================================================
	// control fields, channel two
	logic arm2;
	logic cont2;
	logic src2;
	logic rise_en2;
	logic fall_en2;

	assign arm2 = ctl_q[CTL_ARM2];
	assign cont2 = ctl_q[CTL_CONT2];
	assign src2 = ctl_q[CTL_SRC2];
	assign rise_en2 = ctl_q[CTL_RISE2];
	assign fall_en2 = ctl_q[CTL_FALL2];

	// ====================================================
	// trigger sources
	logic trig1;
	logic trig2;
	logic r1;
	logic f1;
	logic r2;
	logic f2;

	// source switch may itself look like an edge; software should disarm first
	assign trig1 = src1 ? zero_pulse_in : probe1_in;
	assign trig2 = src2 ? zero_pulse_in : probe2_in;

	probe_edge u_edge1 (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.sig_in(trig1),
		.rise_out(r1),
		.fall_out(f1)
	);

	probe_edge u_edge2 (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.sig_in(trig2),
		.rise_out(r2),
		.fall_out(f2)
	);

	// ====================================================
	// channels
	logic act1;
	logic rd1;
	logic fd1;
	logic act2;
	logic rd2;
	logic fd2;

	probe_channel #(.POS_W(POS_WIDTH)) u_ch1 (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.arm_in(arm1),
		.cont_in(cont1),
		.rise_en_in(rise_en1),
		.fall_en_in(fall_en1),
		.rise_in(r1),
		.fall_in(f1),
		.pos_in(position_in),
		.active_out(act1),
		.rise_done_out(rd1),
		.fall_done_out(fd1),
		.rise_pos_out(pos1_rise_out),
		.fall_pos_out(pos1_fall_out)
	);

	probe_channel #(.POS_W(POS_WIDTH)) u_ch2 (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.arm_in(arm2),
		.cont_in(cont2),
		.rise_en_in(rise_en2),
		.fall_en_in(fall_en2),
		.rise_in(r2),
		.fall_in(f2),
		.pos_in(position_in),
		.active_out(act2),
		.rise_done_out(rd2),
		.fall_done_out(fd2),
		.rise_pos_out(pos2_rise_out),
		.fall_pos_out(pos2_fall_out)
	);

	// ====================================================
	// status object and read port
	logic [15:0] sts;

	always_comb begin
		sts = STS_RESET;
		sts[STS_ACT1] = act1;
		sts[STS_RISE1] = rd1;
		sts[STS_FALL1] = fd1;
		sts[STS_ACT2] = act2;
		sts[STS_RISE2] = rd2;
		sts[STS_FALL2] = fd2;
	end

	logic [15:0] rd_word;

	// unread or refused indices answer zero
	always_comb begin
		rd_word = 16'h0000;
		if (rd_ctl) begin
			rd_word = ctl_q;
		end else if (rd_sts) begin
			rd_word = sts;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			obj_rdata_out <= 16'h0000;
		end else begin
			obj_rdata_out <= rd_word;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			obj_rvalid_out <= 1'b0;
		end else begin
			obj_rvalid_out <= obj_rd_in;
		end
	end

	// a read and a write together report only the read decode
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			obj_err_out <= 1'b0;
		end else begin
			obj_err_out <= rd_bad | (wr_bad & ~obj_rd_in);
		end
	end
endmodule

//--- tb/probe_monitor.sv
// assertion checker for the probe capture unit
`timescale 1ns/1ps
module probe_monitor
	import probe_pkg::*;
#(
	parameter int POS_WIDTH = POS_W
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic probe1_in,
	input wire logic [POS_WIDTH-1:0] position_in,
	input wire logic obj_wr_in,
	input wire logic obj_rd_in,
	input wire logic [15:0] obj_addr_in,
	input wire logic [15:0] obj_wdata_in,
	input wire logic [15:0] obj_rdata_out,
	input wire logic [POS_WIDTH-1:0] pos1_rise_out
);
	logic [15:0] ctl_q;
	wire logic rs = obj_rd_in && obj_addr_in == ADDR_STATUS;
	// shadow of the control word, masked as the design stores it
	always_ff @(posedge clk_in)
		if (srst_in)
			ctl_q <= CTL_RESET;
		else if (obj_wr_in && obj_addr_in == ADDR_CONTROL)
			ctl_q <= obj_wdata_in & CTL_WRITE_MASK;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	AST_ACT1: assert property (rs |=> obj_rdata_out[0] == $past(ctl_q[0], 2))
		else $error("arm1");
	AST_ACT2: assert property (rs |=> obj_rdata_out[8] == $past(ctl_q[8], 2))
		else $error("arm2");
	AST_RSV: assert property (rs |=> (obj_rdata_out & 16'hf8f8) == 16'h0000)
		else $error("rsv");
	AST_CTL: assert property (obj_rd_in && obj_addr_in == ADDR_CONTROL |=>
		obj_rdata_out == $past(ctl_q)) else $error("ctl");
	AST_CLR1: assert property (rs && !$past(ctl_q[0]) |=> obj_rdata_out[2:1] == 2'h0)
		else $error("clr1");
	AST_CLR2: assert property (rs && !$past(ctl_q[8]) |=> obj_rdata_out[10:9] == 2'h0)
		else $error("clr2");
	AST_P1R: assert property ((ctl_q & 16'h0017) == 16'h0013 && !$past(ctl_q[2])
		&& !$past(srst_in) && $rose(probe1_in) |=> pos1_rise_out == $past(position_in))
		else $error("cap");
	AST_HOLD: assert property ($changed(pos1_rise_out) |-> $past(ctl_q[0]) || $past(srst_in))
		else $error("hold");
endmodule
bind touch_probe_position_capture probe_monitor #(.POS_WIDTH(POS_WIDTH)) mon (.clk_in, .srst_in,
	.probe1_in, .position_in, .obj_wr_in, .obj_rd_in, .obj_addr_in, .obj_wdata_in,
	.obj_rdata_out, .pos1_rise_out);

//--- tb/probe_src.sv
// probe pin and position source model
`timescale 1ns/1ps
module probe_src (
	input wire logic clk_in,
	output logic [2:0] sig_out = 3'h0,
	output logic [31:0] pos_out = 32'h0
);
	// moves just after an edge, as an upstream synchronised pin would
	task ev(input int w, input logic l, input logic [31:0] p);
		@(posedge clk_in);
		sig_out[w] <= l;
		pos_out <= p;
		@(posedge clk_in);
	endtask
endmodule

//--- tb/touch_probe_position_capture_test.sv
// self-checking bench for the probe capture unit
`timescale 1ns/1ps
module touch_probe_position_capture_test
	import probe_pkg::*;
();
	logic clk_in = 0, srst_in = 1, wr = 0, rd = 0, er, rv;
	logic [15:0] a = 16'h0000, wd = 16'h0000, rdat;
	logic [2:0] sig;
	logic [31:0] pos, p1r, p1f, p2r, p2f;
	int failures = 0, comparisons = 0;
	probe_src P (.clk_in, .sig_out(sig), .pos_out(pos));
	touch_probe_position_capture DUT (.clk_in, .srst_in, .probe1_in(sig[0]), .probe2_in(sig[1]),
		.zero_pulse_in(sig[2]), .position_in(pos), .obj_wr_in(wr), .obj_rd_in(rd),
		.obj_addr_in(a), .obj_wdata_in(wd), .obj_rdata_out(rdat), .obj_rvalid_out(rv),
		.obj_err_out(er), .pos1_rise_out(p1r), .pos1_fall_out(p1f), .pos2_rise_out(p2r),
		.pos2_fall_out(p2f));
	task chk(input logic [63:0] s, e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	// one strobe per access; reads also expect an error flag off the map
	task acc(input logic w, input logic [15:0] ad, d);
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		a <= ad;
		wd <= d;
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		// writes answer nothing but the error pulse off the control index
		if (w)
			chk({rv, er, rdat}, {1'b0, ad != ADDR_CONTROL, 16'h0000});
		else
			chk({rv, er, rdat}, {1'b1, ad[15:1] != 15'h305c, d});
	endtask
	task close_out;
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #12.5 clk_in = ~clk_in;
	// several times the expected run
	initial begin
		#20000;
		failures++;
		close_out;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		acc(0, ADDR_STATUS, STS_RESET);
		acc(0, 16'h60ba, 16'h0000);
		acc(1, ADDR_STATUS, 16'hffff);
		acc(0, ADDR_STATUS, STS_RESET);
		acc(1, ADDR_CONTROL, 16'hffff);
		acc(0, ADDR_CONTROL, CTL_WRITE_MASK);
		acc(0, ADDR_STATUS, 16'h0101);
		acc(1, ADDR_CONTROL, 16'h0031);
		for (int i = 1; i < 5; i++)
			P.ev(0, i[0], i * 256);
		acc(0, ADDR_STATUS, 16'h0007);
		chk({p1r, p1f}, {32'h100, 32'h200});
		acc(1, ADDR_CONTROL, 16'h0000);
		acc(1, ADDR_CONTROL, 16'h0013);
		for (int i = 5; i < 8; i++)
			P.ev(0, i[0], i * 256);
		acc(0, ADDR_STATUS, 16'h0003);
		chk({p1r, p1f}, {32'h700, 32'h200});
		acc(1, ADDR_CONTROL, 16'h0000);
		acc(1, ADDR_CONTROL, 16'h2700);
		for (int i = 9; i < 15; i++)
			P.ev(i < 11 ? 1 : 2, i[0], i * 256);
		acc(0, ADDR_STATUS, 16'h0500);
		chk({p2r, p2f}, {32'h0, 32'he00});
		acc(1, ADDR_CONTROL, 16'h0000);
		acc(1, ADDR_CONTROL, 16'h1115);
		P.ev(2, 1, 32'hf00);
		P.ev(1, 1, 32'h1000);
		acc(0, ADDR_STATUS, 16'h0303);
		chk({p1r, p2r}, {32'hf00, 32'h1000});
		close_out;
	end
endmodule
